//--- logic/adc_channel_range_regs.sv
// Implementation choice: the plain strobed port.
`timescale 1ns/100ps
module adc_channel_range_regs
  import range_regs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [15:0] bus_wdata,
  input wire logic [6:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [15:0] bus_rdata,
  input wire logic manual_mode,
  input wire logic conv_start,
  input wire logic [15:0] conv_data_a,
  input wire logic [15:0] conv_data_b,
  output logic [15:0] result_a,
  output logic [15:0] result_b,
  output range_regs_pkg::chan_sel_t active_sel_a,
  output range_regs_pkg::chan_sel_t active_sel_b,
  output range_regs_pkg::range_t range_a [8],
  output range_regs_pkg::range_t range_b [8],
  output logic reserved_code
);
  import range_regs_pkg::*;

  typedef struct packed {
    logic [8:0] channel;
    logic [8:0] ra1;
    logic [8:0] ra2;
    logic [8:0] rb1;
    logic [8:0] rb2;
    logic [15:0] rdata;
    chan_sel_t sel_a;
    chan_sel_t sel_b;
  } state_t;

  state_t st;
  state_t next_st;
  chan_sel_t dec_a;
  chan_sel_t dec_b;
  logic [8:0] wr_data;
  logic [8:0] rd_word;
  logic [6:0] wr_addr;

  ////////////////////////////////////////////////////////////////////////////
  chan_decoder u_dec_a (
    .code(st.channel[CH_A_LSB +: 4]),
    .sel(dec_a)
  );
  chan_decoder u_dec_b (
    .code(st.channel[CH_B_LSB +: 4]),
    .sel(dec_b)
  );

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_rng
      range_decoder u_ra_lo (.code(st.ra1[2*gi +: 2]), .range(range_a[gi]));
      range_decoder u_ra_hi (.code(st.ra2[2*gi +: 2]), .range(range_a[gi+4]));
      range_decoder u_rb_lo (.code(st.rb1[2*gi +: 2]), .range(range_b[gi]));
      range_decoder u_rb_hi (.code(st.rb2[2*gi +: 2]), .range(range_b[gi+4]));
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // the word carries its own address; bus_addr only steers reads
  assign wr_addr = bus_wdata[ADDR_MSB:ADDR_LSB];
  // reserved bit 8 is kept at zero so readback stays at its reset value
  assign wr_data = bus_wdata[8:0] & DATA_MASK;

  always_comb begin
    unique case (bus_addr)
      ADDR_CHANNEL: rd_word = st.channel;
      ADDR_RANGE_A1: rd_word = st.ra1;
      ADDR_RANGE_A2: rd_word = st.ra2;
      ADDR_RANGE_B1: rd_word = st.rb1;
      ADDR_RANGE_B2: rd_word = st.rb2;
      default: rd_word = 9'h000;
    endcase
  end

  always_comb begin
    next_st = st;
    if (bus_wr) begin
      unique case (wr_addr)
        ADDR_CHANNEL: next_st.channel = wr_data;
        ADDR_RANGE_A1: next_st.ra1 = wr_data;
        ADDR_RANGE_A2: next_st.ra2 = wr_data;
        ADDR_RANGE_B1: next_st.rb1 = wr_data;
        ADDR_RANGE_B2: next_st.rb2 = wr_data;
        default: ;
      endcase
    end
    // readback word carries its address in the top bits
    next_st.rdata = bus_rd ? {bus_addr, rd_word} : 16'h0000;
    // selection is latched at a manual-mode conversion start so a write mid-conversion
    // cannot disturb the sample in flight
    if (conv_start && manual_mode) begin
      next_st.sel_a = dec_a;
      next_st.sel_b = dec_b;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st.channel <= CHANNEL_RESET;
      st.ra1 <= RANGE_RESET;
      st.ra2 <= RANGE_RESET;
      st.rb1 <= RANGE_RESET;
      st.rb2 <= RANGE_RESET;
      st.rdata <= 16'h0000;
      st.sel_a <= '{source: SRC_INPUT, pair: 3'h0, valid: 1'b1};
      st.sel_b <= '{source: SRC_INPUT, pair: 3'h0, valid: 1'b1};
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign bus_rdata = st.rdata;
  assign active_sel_a = st.sel_a;
  assign active_sel_b = st.sel_b;
  assign reserved_code = !dec_a.valid || !dec_b.valid;
  // pattern replaces the converter words so the host can test its port
  assign result_a = (st.sel_a.source == SRC_PATTERN) ? PATTERN_A
                    : conv_data_a;
  assign result_b = (st.sel_b.source == SRC_PATTERN) ? PATTERN_B
                    : conv_data_b;

  ////////////////////////////////////////////////////////////////////////////
  chk_write_channel: assert property (@(posedge sys_clk) disable iff (rst)
    bus_wr && bus_wdata[15:9] == ADDR_CHANNEL |=>
      st.channel == $past(bus_wdata[8:0] & DATA_MASK))
    else $error("channel write not stored");
  chk_write_range: assert property (@(posedge sys_clk) disable iff (rst)
    bus_wr && bus_wdata[15:9] == ADDR_RANGE_A1 |=>
      st.ra1 == $past(bus_wdata[8:0] & DATA_MASK))
    else $error("range A1 write not stored");
  chk_reserved_bit: assert property (@(posedge sys_clk) disable iff (rst)
    !st.channel[RSVD_BIT] && !st.ra1[RSVD_BIT])
    else $error("reserved bit set");
  chk_pattern_out: assert property (@(posedge sys_clk) disable iff (rst)
    conv_start && manual_mode && st.channel[3:0] == CODE_PATTERN |=>
      result_a == PATTERN_A)
    else $error("pattern A missing");
  chk_pattern_b: assert property (@(posedge sys_clk) disable iff (rst)
    conv_start && manual_mode && st.channel[7:4] == CODE_PATTERN |=>
      result_b == PATTERN_B)
    else $error("pattern B missing");
  chk_pair_select: assert property (@(posedge sys_clk) disable iff (rst)
    conv_start && manual_mode && st.channel[7:4] <= CODE_LAST_PAIR |=>
      st.sel_b.source == SRC_INPUT && st.sel_b.pair == $past(st.channel[6:4]))
    else $error("B pair wrong");
  chk_same_table: assert property (@(posedge sys_clk) disable iff (rst)
    st.channel[3:0] == st.channel[7:4] |-> dec_a == dec_b)
    else $error("A and B decode differ");
  chk_hold_sel: assert property (@(posedge sys_clk) disable iff (rst)
    !(conv_start && manual_mode) |=> $stable(st.sel_a))
    else $error("selection moved without start");
  chk_range_map: assert property (@(posedge sys_clk) disable iff (rst)
    st.ra1[7:6] == 2'b01 |-> range_a[3] == RANGE_2V5)
    else $error("range field map wrong");
  chk_range_ten: assert property (@(posedge sys_clk) disable iff (rst)
    st.ra1[1:0] == 2'b11 |-> range_a[0] == RANGE_10V)
    else $error("code 11 not 10 V");
  chk_read_data: assert property (@(posedge sys_clk) disable iff (rst)
    bus_rd && bus_addr == ADDR_RANGE_A1 && !bus_wr |=>
      bus_rdata[8:0] == $past(st.ra1))
    else $error("readback wrong");
  chk_reserved_flag: assert property (@(posedge sys_clk) disable iff (rst)
    st.channel[3:0] == CODE_RSVD_A |-> reserved_code && !dec_a.valid)
    else $error("reserved A code not flagged");
  chk_pattern_hold: assert property (@(posedge sys_clk) disable iff (rst)
    st.sel_a.source != SRC_PATTERN |-> result_a == conv_data_a)
    else $error("result A replaced without pattern");

  cov_pattern: cover property (@(posedge sys_clk) disable iff (rst)
    conv_start && manual_mode && st.channel[3:0] == CODE_PATTERN);
  cov_supply: cover property (@(posedge sys_clk) disable iff (rst)
    conv_start && manual_mode && st.channel[7:4] == CODE_SUPPLY);
  cov_range_write: cover property (@(posedge sys_clk) disable iff (rst)
    bus_wr && bus_wdata[15:9] == ADDR_RANGE_A1);
  cov_read_back: cover property (@(posedge sys_clk) disable iff (rst)
    bus_rd && bus_addr == ADDR_CHANNEL);
endmodule

//--- logic/range_regs_pkg.sv
package range_regs_pkg;
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam logic [6:0] ADDR_CONFIG = 7'h02;
  localparam logic [6:0] ADDR_CHANNEL = 7'h03;
  localparam logic [6:0] ADDR_RANGE_A1 = 7'h04;
  localparam logic [6:0] ADDR_RANGE_A2 = 7'h05;
  localparam logic [6:0] ADDR_RANGE_B1 = 7'h06;
  localparam logic [6:0] ADDR_RANGE_B2 = 7'h07;
  localparam int ADDR_MSB = 15;
  localparam int ADDR_LSB = 9;
  localparam int RSVD_BIT = 8;
  localparam int CH_B_LSB = 4;
  localparam int CH_A_LSB = 0;
  localparam logic [8:0] CHANNEL_RESET = 9'h000;
  localparam logic [8:0] RANGE_RESET = 9'h0FF;
  localparam logic [8:0] DATA_MASK = 9'h0FF;
  localparam logic [3:0] CODE_LAST_PAIR = 4'h7;
  localparam logic [3:0] CODE_SUPPLY = 4'h8;
  localparam logic [3:0] CODE_REGULATOR = 4'h9;
  localparam logic [3:0] CODE_RSVD_A = 4'hA;
  localparam logic [3:0] CODE_PATTERN = 4'hB;
  localparam logic [3:0] CODE_RSVD_C = 4'hC;
  localparam logic [15:0] PATTERN_A = 16'hAAAA;
  localparam logic [15:0] PATTERN_B = 16'h5555;

  typedef enum logic [1:0] {
    SRC_INPUT = 2'b00,
    SRC_SUPPLY = 2'b01,
    SRC_REGULATOR = 2'b10,
    SRC_PATTERN = 2'b11
  } source_t;

  typedef enum logic [1:0] {
    RANGE_10V = 2'b00,
    RANGE_2V5 = 2'b01,
    RANGE_5V = 2'b10
  } range_t;

  typedef struct packed {
    source_t source;
    logic [2:0] pair;
    logic valid;
  } chan_sel_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] wdata;
  } bus_req_t;
endpackage

//--- logic/chan_decoder.sv
`timescale 1ns/100ps
module chan_decoder
  import range_regs_pkg::*;
(
  input wire logic [3:0] code,
  output range_regs_pkg::chan_sel_t sel
);
  always_comb begin
    sel = '{source: SRC_INPUT, pair: code[2:0], valid: 1'b1};
    if (code > CODE_LAST_PAIR) begin
      unique case (code)
        CODE_SUPPLY: sel.source = SRC_SUPPLY;
        CODE_REGULATOR: sel.source = SRC_REGULATOR;
        CODE_PATTERN: sel.source = SRC_PATTERN;
        default: sel.valid = 1'b0;
      endcase
    end
  end
endmodule

//--- logic/range_decoder.sv
`timescale 1ns/100ps
module range_decoder
  import range_regs_pkg::*;
(
  input wire logic [1:0] code,
  output range_regs_pkg::range_t range
);
  // code 11 duplicates the 10 V range
  always_comb begin
    unique case (code)
      2'b01: range = RANGE_2V5;
      2'b10: range = RANGE_5V;
      default: range = RANGE_10V;
    endcase
  end
endmodule

//--- bench/host_model.sv
`timescale 1ns/100ps
module host_model (
  input wire logic sys_clk,
  input wire logic [15:0] rdata,
  output logic [15:0] bus_wdata,
  output logic [6:0] bus_addr,
  output logic bus_wr,
  output logic bus_rd
);
  initial begin
    bus_wdata = 16'h0000;
    bus_addr = 7'h00;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
  end
  // idle bus shows the inverse so a stale word cannot pass for a live one
  task automatic wr(input logic [6:0] a, input logic [8:0] d);
    @(posedge sys_clk);
    bus_wr <= 1'b1;
    bus_wdata <= {a, d};
    @(posedge sys_clk);
    bus_wr <= 1'b0;
    bus_wdata <= ~{a, d};
  endtask
  task automatic rd(input logic [6:0] a, output logic [15:0] q);
    @(posedge sys_clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge sys_clk);
    bus_rd <= 1'b0;
    bus_addr <= ~a;
    #1;
    q = rdata;
  endtask
endmodule

//--- bench/tb_adc_channel_range_regs.sv
`timescale 1ns/100ps
module tb_adc_channel_range_regs;
  import range_regs_pkg::*;
  logic sys_clk, rst, manual_mode, conv_start, bus_wr, bus_rd, reserved_code;
  logic [15:0] bus_wdata, bus_rdata, conv_data_a, conv_data_b;
  logic [15:0] result_a, result_b, q;
  logic [6:0] bus_addr, a;
  logic [8:0] d;
  // channel word in force at the last manual start, not the register value
  logic [8:0] lat;
  logic [8:0] shadow [3:7];
  chan_sel_t active_sel_a, active_sel_b;
  range_t range_a [8];
  range_t range_b [8];
  int mismatches = 0;
  int n_checks = 0;
  adc_channel_range_regs i_dut (.sys_clk, .rst, .bus_wdata, .bus_addr,
    .bus_wr, .bus_rd, .bus_rdata, .manual_mode, .conv_start, .conv_data_a,
    .conv_data_b, .result_a, .result_b, .active_sel_a, .active_sel_b,
    .range_a, .range_b, .reserved_code);
  host_model i_host (.sys_clk, .rdata(bus_rdata), .bus_wdata, .bus_addr,
    .bus_wr, .bus_rd);
  initial begin
    sys_clk = 1'b0;
    forever #(CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////////////
  function automatic range_t exp_rng(input logic [1:0] c);
    return (c == 2'b01) ? RANGE_2V5 : (c == 2'b10) ? RANGE_5V : RANGE_10V;
  endfunction
  function automatic logic is_rsv(input logic [3:0] c);
    return (c == CODE_RSVD_A) || (c >= CODE_RSVD_C);
  endfunction
  task automatic chk(input string n, input logic [15:0] e, s);
    n_checks++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic check_reg(input logic [6:0] r);
    int k;
    i_host.rd(r, q);
    chk("rdata", {r, shadow[r]}, q);
    for (k = 0; k < 4 && r != ADDR_CHANNEL; k++) begin
      chk("range", 16'(exp_rng(shadow[r][2*k+:2])), 16'(r[1] ?
        range_b[k + (r[0] ? 4 : 0)] :
        range_a[k + (r[0] ? 4 : 0)]));
    end
  endtask
  task automatic pulse(input logic m);
    @(posedge sys_clk);
    manual_mode <= m;
    conv_start <= 1'b1;
    conv_data_a <= 16'($urandom);
    conv_data_b <= 16'($urandom);
    @(posedge sys_clk);
    conv_start <= 1'b0;
    #1;
  endtask
  task automatic chk_side(input logic [3:0] c, input chan_sel_t s,
      input logic [15:0] r, dv, p);
    chk("valid", 16'(!is_rsv(c)), 16'(s.valid));
    if (!is_rsv(c))
      chk("source", 16'(c <= CODE_LAST_PAIR ? SRC_INPUT : c == CODE_SUPPLY ?
        SRC_SUPPLY : c == CODE_REGULATOR ? SRC_REGULATOR : SRC_PATTERN),
        16'(s.source));
    if (c <= CODE_LAST_PAIR)
      chk("pair", 16'(c[2:0]), 16'(s.pair));
    chk("result", (c == CODE_PATTERN) ? p : dv, r);
  endtask
  task automatic test_done();
    if (mismatches == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    mismatches++;
    test_done();
  end
  initial begin
    void'($urandom(11194));
    rst = 1'b1;
    manual_mode = 1'b0;
    conv_start = 1'b0;
    conv_data_a = 16'h0000;
    conv_data_b = 16'h0000;
    for (int i = 3; i < 8; i++)
      shadow[i] = (i == 3) ? CHANNEL_RESET : RANGE_RESET;
    lat = CHANNEL_RESET;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    chk("sel_a", 16'(active_sel_a), 16'({SRC_INPUT, 3'h0, 1'b1}));
    for (int i = 3; i < 8; i++) check_reg(7'(i));
    @(posedge sys_clk);
    #1;
    chk("rdata_idle", 16'h0000, bus_rdata);
    // the config word lives elsewhere: here it must not alias a register
    i_host.wr(ADDR_CONFIG, 9'(16'($urandom)));
    i_host.rd(ADDR_CONFIG, q);
    chk("unmapped", 16'h0000, 16'(q[8:0]));
    repeat (20) begin
      a = 7'(3 + $urandom % 5);
      d = 9'($urandom) | 9'h100;
      i_host.wr(a, d);
      shadow[a] = d & DATA_MASK;
      check_reg(a);
    end
    for (int i = 3; i < 8; i++) check_reg(7'(i));
    // every code on both sides; a non-manual start must leave the selection
    for (int i = 0; i < 16; i++) begin
      d = {1'b0, 4'(15 - i), 4'(i)};
      i_host.wr(ADDR_CHANNEL, d);
      #1;
      chk("reserved", 16'(is_rsv(d[3:0]) || is_rsv(d[7:4])),
        16'(reserved_code));
      pulse(1'b0);
      chk_side(lat[3:0], active_sel_a, result_a, conv_data_a,
        PATTERN_A);
      chk_side(lat[7:4], active_sel_b, result_b, conv_data_b,
        PATTERN_B);
      pulse(1'b1);
      shadow[3] = d;
      lat = d;
      chk_side(d[3:0], active_sel_a, result_a, conv_data_a,
        PATTERN_A);
      chk_side(d[7:4], active_sel_b, result_b, conv_data_b,
        PATTERN_B);
    end
    test_done();
  end
endmodule
